// [bench/relay_checker_assertions.sv]
// Assertions on relay timing and lamps
`default_nettype none
module relay_checker_assertions
  import tilt_level_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // Watched ports
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic probe_contact_closed,
  input wire logic [1:0] polarity_selector,
  input wire logic [DELAY_WIDTH-1:0] delay_adjust_setting,
  input wire logic relay_energize,
  input wire logic lamp_normal,
  input wire logic lamp_alarm
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bound scales with the tick length of the watched instance
  localparam int MAX_WAIT = DELAY_MAX_TICKS * TICK_CYCLES_P + 2;
  wire logic want = polarity_selector == SEL_POS1 ? probe_contact_closed :
    polarity_selector == SEL_POS2 ? !probe_contact_closed : 1'b0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_up; !relay_energize && !want ##1 want; endsequence
  sequence s_down; relay_energize && want ##1 !want; endsequence
  a_lamp_green: assert property (lamp_normal == relay_energize)
    else $error("green lamp wrong");
  a_lamp_red: assert property (lamp_alarm == !relay_energize)
    else $error("red lamp wrong");
  a_reset_off: assert property (disable iff (1'b0) !reset_n |=> !relay_energize && lamp_alarm)
    else $error("relay on in reset");
  a_up_hold: assert property (s_up |-> !relay_energize [*3])
    else $error("early energize");
  a_down_hold: assert property (s_down |-> relay_energize [*3])
    else $error("early release");
  a_up_bound: assert property (s_up |-> ##[1:MAX_WAIT] (relay_energize || !want))
    else $error("energize late");
  a_rise_cause: assert property ($rose(relay_energize) |-> $past(want))
    else $error("energize without cause");
  a_fall_cause: assert property ($fell(relay_energize) && $past(reset_n) |-> !$past(want))
    else $error("release without cause");
endmodule
bind tilt_level_relay_control relay_checker_assertions #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk (
  .core_clk, .reset_n, .probe_contact_closed, .polarity_selector, .delay_adjust_setting,
  .relay_energize, .lamp_normal, .lamp_alarm);
`default_nettype wire

// [bench/tilt_level_relay_control_tb_top.sv]
// Self-checking bench for the tilt level relay control
`default_nettype none
module tilt_level_relay_control_tb_top;
  import tilt_level_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, reset_n = 1'b0, tilted = 1'b0, probe_contact_closed, w, prev;
  logic [1:0] polarity_selector = 2'h1;
  logic [8:0] delay_adjust_setting = 9'h1;
  logic relay_energize, lamp_normal, lamp_alarm;
  int error_cnt, comparisons, de;
  always #10 core_clk = !core_clk;
  tilt_probe_model probe (.tilted, .probe_contact_closed);
  tilt_level_relay_control #(.TICK_CYCLES_P(2)) dut (.core_clk, .reset_n,
    .probe_contact_closed, .polarity_selector, .delay_adjust_setting,
    .relay_energize, .lamp_normal, .lamp_alarm);
  function automatic logic want_of(logic [1:0] s, logic t);
    return s == SEL_POS1 ? !t : s == SEL_POS2 ? t : 1'b0;
  endfunction
  task automatic check(string nm, logic seen, logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(2));
    prev = 1'b0;
    repeat (10) @(negedge core_clk);
    check("alarm in reset", lamp_alarm, 1'b1);
    reset_n = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      // Zero and oversize settings reach the clamp in steps 0 and 1, where the relay never moves
      delay_adjust_setting = (i == 0) ? 9'h0 : (i == 1) ? 9'h1ff : 9'(1 + $urandom % 4);
      de = (i == 0) ? 1 : (i == 1) ? 350 : int'(delay_adjust_setting);
      polarity_selector = 2'(i);
      tilted = 1'($urandom % 2);
      w = want_of(polarity_selector, tilted);
      @(negedge core_clk);
      check("relay held", relay_energize, prev);
      if (w != prev && (i % 4 == 1 || i % 4 == 2) && i < 8)
      begin
        tilted = !tilted;
        w = prev;
      end
      repeat (2 * de + 2) @(negedge core_clk);
      check("relay", relay_energize, w);
      check("green", lamp_normal, w);
      check("red", lamp_alarm, !w);
      prev = w;
    end
    reset_n = 1'b0;
    @(negedge core_clk);
    check("relay after reset", relay_energize, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire

// [bench/tilt_probe_model.sv]
// Remote tilt probe: one normally closed contact
`default_nettype none
module tilt_probe_model
(
  // Probe attitude and contact
  input wire logic tilted,
  output logic probe_contact_closed
);
  timeunit 1ns;
  timeprecision 1ns;
  assign probe_contact_closed = !tilted;
endmodule
`default_nettype wire

// [pkg/tilt_level_pkg.sv]
// Constants and types for the tilt level relay control
// Behaviour
// - Closed contact vertical, open contact tilted
// - Relay change delayed, 0.1 to 35 s
// - Delay end sets relay to the wanted level
// - Power loss leaves relay de-energized
// - Green lamp lit while relay energized
// - Red lamp lit while relay de-energized
// - Both lamps dark only without power
// - Position 1: energize when probe vertical
// - Position 2: energize when probe tilted
// - Middle selector setting chooses no polarity
`default_nettype none
package tilt_level_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DELAY_MIN_MS = 100;
  localparam int unsigned DELAY_MAX_MS = 35_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DELAY_MIN_TICKS = DELAY_MIN_MS / TICK_MS;
  localparam int unsigned DELAY_MAX_TICKS = DELAY_MAX_MS / TICK_MS;
  localparam int unsigned TICK_WIDTH = 23;
  localparam int unsigned DELAY_WIDTH = 9;

  // ----------------------------------------
  // Selector codes
  // ----------------------------------------
  localparam logic [1:0] SEL_POS1 = 2'h1;
  localparam logic [1:0] SEL_POS2 = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1
  } relay_state_type;

endpackage
`default_nettype wire

// [rtl/tilt_level_relay_control.sv]
// Tilt probe readout with delayed relay and status lamps
`default_nettype none
module tilt_level_relay_control
  import tilt_level_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Probe and settings
  input wire logic probe_contact_closed,
  input wire logic [1:0] polarity_selector,
  input wire logic [DELAY_WIDTH-1:0] delay_adjust_setting,
  // Outputs
  output logic relay_energize,
  output logic lamp_normal,
  output logic lamp_alarm
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic probe_vertical;
  logic want_energize;
  logic [DELAY_WIDTH-1:0] delay_ticks;
  logic [TICK_WIDTH-1:0] tick_q;
  logic tick;
  logic restart;
  relay_state_type state_q;
  logic [DELAY_WIDTH-1:0] count_q;
  logic relay_d;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Relay level asked for by selector and probe attitude
  function automatic logic want_from(input logic [1:0] sel, input logic vertical);
    logic result;
    result = 1'b0;
    unique case (sel)
      SEL_POS1:
      begin
        result = vertical;
      end
      SEL_POS2:
      begin
        result = !vertical;
      end
      // Null or both contacts: no polarity chosen, stay safe
      default:
      begin
        result = 1'b0;
      end
    endcase
    return result;
  endfunction

  // Knob reading forced into its legal span
  function automatic logic [DELAY_WIDTH-1:0] clamp_delay(input logic [DELAY_WIDTH-1:0] raw);
    logic [DELAY_WIDTH-1:0] result;
    result = raw;
    if (raw < DELAY_WIDTH'(DELAY_MIN_TICKS))
    begin
      result = DELAY_WIDTH'(DELAY_MIN_TICKS);
    end
    else if (raw > DELAY_WIDTH'(DELAY_MAX_TICKS))
    begin
      result = DELAY_WIDTH'(DELAY_MAX_TICKS);
    end
    return result;
  endfunction

  // Last tick of the last delay unit; shared so that the state
  // machine and the relay can never disagree on expiry
  function automatic logic delay_done(input logic tick_now, input logic [DELAY_WIDTH-1:0] left);
    return tick_now && (left == DELAY_WIDTH'(1));
  endfunction

  // ----------------------------------------
  // Desired relay level
  // ----------------------------------------
  assign probe_vertical = probe_contact_closed;

  always_comb
  begin
    want_energize = want_from(polarity_selector, probe_vertical);
  end

  always_comb
  begin
    delay_ticks = clamp_delay(delay_adjust_setting);
  end

  // ----------------------------------------
  // 100 ms tick divider, restarted with the delay
  // ----------------------------------------
  // Restarting keeps the first delay unit a full tick long
  assign tick = (tick_q == TICK_WIDTH'(TICK_CYCLES_P - 1));

  always_ff @(posedge core_clk)
  begin
    if (!reset_n || restart || tick)
    begin
      tick_q <= '0;
    end
    else
    begin
      tick_q <= tick_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Delay state machine
  // ----------------------------------------
  // Any mismatch appearing restarts the wait; one vanishing cancels it
  assign restart = (state_q == ST_IDLE) && (want_energize != relay_energize);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (restart)
          begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (want_energize == relay_energize)
          begin
            state_q <= ST_IDLE;
          end
          else if (delay_done(tick, count_q))
          begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      count_q <= '0;
    end
    else if (restart)
    begin
      count_q <= delay_ticks;
    end
    else if (state_q == ST_WAIT && tick && count_q != '0)
    begin
      count_q <= count_q - 1'b1;
    end
  end

  // ----------------------------------------
  // Output relay
  // ----------------------------------------
  // Relay moves only at the expiry of an unbroken wait
  always_comb
  begin
    relay_d = relay_energize;
    if (state_q == ST_WAIT && want_energize != relay_energize
        && delay_done(tick, count_q))
    begin
      relay_d = want_energize;
    end
  end

  // Reset stands in for power loss: relay held off
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      relay_energize <= 1'b0;
    end
    else
    begin
      relay_energize <= relay_d;
    end
  end

  // ----------------------------------------
  // Lamps: exactly one lit whenever powered
  // ----------------------------------------
  // Registered from the relay's own next value, so a lamp can
  // never show a state that the relay does not have
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      lamp_normal <= 1'b0;
    end
    else
    begin
      lamp_normal <= relay_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      lamp_alarm <= 1'b1;
    end
    else
    begin
      lamp_alarm <= !relay_d;
    end
  end

endmodule
`default_nettype wire
